// [bench/sol_cfg_monitor.sv]
// Port-level assertions for the configuration block.
// Assumes one clock and the synchronous reset of the block.
`include "sol_defines.vh"
module sol_cfg_monitor (
	input logic                 clk,
	input logic                 sys_rst,
	input logic                 reg_wr,
	input logic                 reg_rd,
	input logic [`SOL_DW-1:0]   reg_rdata,
	input logic                 loop_a_powerdown_pin,
	input logic                 serial_read_data,
	input logic [1:0]           first_out_drive_select,
	input logic                 drive_cmos,
	input logic                 drive_lvds,
	input logic                 drive_pecl,
	input logic                 drive_hcsl,
	input logic                 first_out_p,
	input logic                 first_out_n,
	input logic                 first_out_n_oe,
	input logic [7:0]           loop_a_fb_integer,
	input logic [2:0]           interp_bits,
	input logic [2:0]           sdm_bits,
	input logic                 detector_pump_power_on,
	input logic                 oscillator_power_on,
	input logic                 fb_div_power_on,
	input logic                 readback_or_unlock_pin,
	input logic                 irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Properties
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 40'h00_0000_0000)
		else $error("read data outside its slot");
	a_drive_decode: assert property (
		{drive_hcsl, drive_pecl, drive_lvds, drive_cmos} == (4'h1 << $past(first_out_drive_select)))
		else $error("drive decode wrong");
	a_oe_mode: assert property (first_out_n_oe == !drive_cmos)
		else $error("complement enable wrong");
	a_comp_pair: assert property (first_out_n == !first_out_p)
		else $error("complement output wrong");
	a_drive_hold: assert property (!$past(reg_wr) |-> $stable(first_out_drive_select))
		else $error("drive select moved without write");
	a_int_hold: assert property (!$past(reg_wr, 2) |-> $stable(loop_a_fb_integer))
		else $error("integer moved without write");
	a_int_route: assert property (interp_bits == 3'h0 || sdm_bits == 3'h0)
		else $error("both routes active");
	a_pd_off: assert property (loop_a_powerdown_pin [*5] |->
		!detector_pump_power_on && !oscillator_power_on && !fb_div_power_on)
		else $error("subsystem powered while pin down");
	a_pin_source: assert property (readback_or_unlock_pin == $past(serial_read_data) ||
		readback_or_unlock_pin == $past(irq))
		else $error("shared pin source wrong");
endmodule

bind sol_cfg_top sol_cfg_monitor u_mon (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_rdata,
	.loop_a_powerdown_pin, .serial_read_data, .first_out_drive_select, .drive_cmos,
	.drive_lvds, .drive_pecl, .drive_hcsl, .first_out_p, .first_out_n, .first_out_n_oe,
	.loop_a_fb_integer, .interp_bits, .sdm_bits, .detector_pump_power_on,
	.oscillator_power_on, .fb_div_power_on, .readback_or_unlock_pin, .irq);

// [bench/sol_cfg_top_bench.sv]
// Self-checking bench for the configuration block.
// Assumes the strobe register port and the offsets of the defines header.
`include "sol_defines.vh"
module sol_cfg_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, sys_rst, reg_wr, reg_rd, loop_a_powerdown_pin, lock_detect_pin, serial_read_data;
	logic [7:0]  reg_addr, loop_a_fb_integer;
	logic [39:0] reg_wdata, reg_rdata, w;
	logic [1:0]  first_out_drive_select;
	logic        drive_cmos, drive_lvds, drive_pecl, drive_hcsl, first_out_p, first_out_n, first_out_n_oe;
	logic        second_out, third_out, fourth_out, irq, readback_or_unlock_pin;
	logic [27:0] loop_a_fb_fraction;
	logic [5:0]  loop_a_denominator;
	logic [2:0]  interp_bits, sdm_bits;
	logic        detector_pump_power_on, oscillator_power_on, fb_div_power_on;
	int          num_errors, comparisons, i;
	wire  [3:0]  outs = {fourth_out, third_out, second_out, first_out_p};
	wire  [2:0]  pwr = {detector_pump_power_on, oscillator_power_on, fb_div_power_on};

	sol_cfg_top u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.loop_a_powerdown_pin, .lock_detect_pin, .serial_read_data, .first_out_drive_select,
		.drive_cmos, .drive_lvds, .drive_pecl, .drive_hcsl, .first_out_p, .first_out_n,
		.first_out_n_oe, .second_out, .third_out, .fourth_out, .loop_a_fb_integer,
		.loop_a_fb_fraction, .loop_a_denominator, .interp_bits, .sdm_bits,
		.detector_pump_power_on, .oscillator_power_on, .fb_div_power_on,
		.readback_or_unlock_pin, .irq);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================================
	// Access and compare tasks
	task tally_and_finish;
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [39:0] g, input logic [39:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %0t port %h exp %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [39:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task rd_chk(input logic [7:0] a, input logic [39:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		comparisons++;
		if (reg_rdata !== e) begin
			num_errors++;
			$display("FAIL %0t reg %h read %h exp %h", $time, a, reg_rdata, e);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Rise-to-rise distance, bounded so a dead output cannot hang the run
	task period(input int k, input int e);
		int n, r, t0;
		logic p;
		p = outs[k];
		r = 0;
		t0 = 0;
		for (n = 0; n < 1200 && r < 2; n++) begin
			@(posedge clk);
			#1;
			if (outs[k] && !p) begin
				r++;
				if (r == 1)
					t0 = n;
			end
			p = outs[k];
		end
		if (r < 2) begin
			num_errors++;
			tally_and_finish;
		end else begin
			chk(40'(n - 1 - t0), 40'(e));
		end
	endtask

	initial begin
		#100000;
		num_errors++;
		tally_and_finish;
	end

	// ==========================================================
	// Sequence
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, loop_a_powerdown_pin, lock_detect_pin, serial_read_data} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 40'h00_0000_0000;
		num_errors = 0;
		comparisons = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		tick(3);
		rd_chk(`SOL_OFF_DRIVE, 40'h0);
		rd_chk(`SOL_OFF_ODIV, 40'h0);
		rd_chk(`SOL_OFF_LOOPA, 40'h00_0000_000e);
		rd_chk(`SOL_OFF_MASK, 40'h0);
		chk(pwr, 3'h7);
		for (i = 0; i < 4; i++) begin
			wr(`SOL_OFF_DRIVE, 40'(i));
			tick(2);
			chk({drive_hcsl, drive_pecl, drive_lvds, drive_cmos}, 40'h1 << i);
			chk(first_out_n_oe, i != 0);
		end
		wr(`SOL_OFF_ODIV, 40'h00_0703_0504);
		rd_chk(`SOL_OFF_ODIV, 40'h00_0703_0504);
		period(0, 4);
		period(1, 5);
		period(2, 259);
		period(3, 7);
		wr(8'h07, 40'hff_ffff_ffff);
		rd_chk(8'h07, 40'h0);
		w = 40'h1e_5555_555e;
		wr(`SOL_OFF_LOOPA, w);
		tick(2);
		chk(loop_a_fb_integer, w[39:32]);
		chk(loop_a_fb_fraction, {w[31:10], w[9:4]});
		chk(loop_a_denominator, 6'h00);
		wr(`SOL_OFF_MODE, 40'h2);
		tick(2);
		chk(loop_a_fb_fraction, {w[31:10], 6'h00});
		chk(loop_a_denominator, w[9:4]);
		wr(`SOL_OFF_MODE, 40'h1);
		tick(2);
		chk({interp_bits, sdm_bits}, {3'h0, w[31:29]});
		wr(`SOL_OFF_MODE, 40'h5);
		tick(2);
		chk({interp_bits, sdm_bits}, {w[31:29], 3'h0});
		wr(`SOL_OFF_LOOPA, 40'h17_5555_541e);
		rd_chk(`SOL_OFF_STAT, 40'h0);
		wr(`SOL_OFF_LOOPA, 40'h16_5555_540e);
		tick(2);
		chk(irq, 1'b0);
		rd_chk(`SOL_OFF_STAT, 40'h6);
		wr(`SOL_OFF_MASK, 40'h6);
		tick(2);
		chk(irq, 1'b1);
		// Interrupt high but readback low: pin must follow readback
		chk(readback_or_unlock_pin, 1'b0);
		@(posedge clk) serial_read_data <= 1'b1;
		tick(2);
		chk(readback_or_unlock_pin, 1'b1);
		wr(`SOL_OFF_LOOPA, 40'h1e_5555_555f);
		@(posedge clk) serial_read_data <= 1'b0;
		tick(2);
		chk(readback_or_unlock_pin, 1'b1);
		wr(`SOL_OFF_STAT, 40'h6);
		tick(2);
		chk({irq, readback_or_unlock_pin}, 2'h0);
		@(posedge clk) lock_detect_pin <= 1'b1;
		tick(4);
		@(posedge clk) lock_detect_pin <= 1'b0;
		tick(5);
		rd_chk(`SOL_OFF_STAT, 40'h1);
		@(posedge clk) loop_a_powerdown_pin <= 1'b1;
		tick(5);
		chk(pwr, 3'h0);
		@(posedge clk) loop_a_powerdown_pin <= 1'b0;
		tick(5);
		chk(pwr, 3'h7);
		wr(`SOL_OFF_LOOPA, 40'h1e_5555_5558);
		tick(2);
		chk(pwr, 3'h4);
		wr(`SOL_OFF_LOOPA, 40'h1e_5555_5556);
		tick(2);
		chk(pwr, 3'h3);
		wr(`SOL_OFF_MODE, 40'h3);
		tick(2);
		chk({loop_a_fb_fraction, loop_a_denominator, interp_bits, sdm_bits}, 40'h0);
		wr(`SOL_OFF_LOOPA, 40'h1e_5555_540e);
		rd_chk(`SOL_OFF_STAT, 40'h1);
		wr(`SOL_OFF_MODE, 40'h1);
		rd_chk(`SOL_OFF_STAT, 40'h5);
		tally_and_finish;
	end
endmodule

// [verilog/sol_cfg_top.v]
// Output and loop A configuration block of the dual-loop synthesizer.
// Assumes one clock; pins for power-down and lock arrive asynchronously,
// serial read data comes from logic on the same clock.
`include "sol_defines.vh"
module sol_cfg_top (
	clk,
	sys_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	loop_a_powerdown_pin,
	lock_detect_pin,
	serial_read_data,
	first_out_drive_select,
	drive_cmos,
	drive_lvds,
	drive_pecl,
	drive_hcsl,
	first_out_p,
	first_out_n,
	first_out_n_oe,
	second_out,
	third_out,
	fourth_out,
	loop_a_fb_integer,
	loop_a_fb_fraction,
	loop_a_denominator,
	interp_bits,
	sdm_bits,
	detector_pump_power_on,
	oscillator_power_on,
	fb_div_power_on,
	readback_or_unlock_pin,
	irq
);
	input  wire                      clk;
	input  wire                      sys_rst;
	input  wire [`SOL_AW-1:0]        reg_addr;
	input  wire [`SOL_DW-1:0]        reg_wdata;
	input  wire                      reg_wr;
	input  wire                      reg_rd;
	output reg  [`SOL_DW-1:0]        reg_rdata;
	input  wire                      loop_a_powerdown_pin;
	input  wire                      lock_detect_pin;
	input  wire                      serial_read_data;
	output wire [1:0]                first_out_drive_select;
	output reg                       drive_cmos;
	output reg                       drive_lvds;
	output reg                       drive_pecl;
	output reg                       drive_hcsl;
	output wire                      first_out_p;
	output wire                      first_out_n;
	output reg                       first_out_n_oe;
	output wire                      second_out;
	output wire                      third_out;
	output wire                      fourth_out;
	output reg  [7:0]                loop_a_fb_integer;
	output reg  [`SOL_FRAC_W-1:0]    loop_a_fb_fraction;
	output reg  [5:0]                loop_a_denominator;
	output reg  [2:0]                interp_bits;
	output reg  [2:0]                sdm_bits;
	output reg                       detector_pump_power_on;
	output reg                       oscillator_power_on;
	output reg                       fb_div_power_on;
	output reg                       readback_or_unlock_pin;
	output wire                      irq;

	// ==========================================================
	// Register state
	reg  [7:0]              drive_q;
	reg  [31:0]             odiv_q;
	reg  [`SOL_DW-1:0]      loopa_q;
	reg  [3:0]              mode_q;
	reg  [`SOL_ST_W-1:0]    status_q;
	reg  [`SOL_ST_W-1:0]    status_d;
	reg  [`SOL_ST_W-1:0]    mask_q;
	reg  [`SOL_ST_W-1:0]    event_d;
	reg                     lock_prev_q;

	wire                    pd_sync;
	wire                    lock_sync;
	wire [1:0]              loop_mode;
	wire [1:0]              interp_sel;
	wire                    wr_drive;
	wire                    wr_odiv;
	wire                    wr_loopa;
	wire                    wr_mode;
	wire                    wr_stat;
	wire                    wr_mask;
	wire [7:0]              new_int;
	wire [5:0]              new_low;

	function hit;
		input [`SOL_AW-1:0] addr;
		input [`SOL_AW-1:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	function [7:0] odiv_field;
		input [31:0] word;
		input [1:0]  idx;
		begin
			odiv_field = word[idx*`SOL_ODIV_W +: `SOL_ODIV_W];
		end
	endfunction

	assign wr_drive  = reg_wr & hit(reg_addr, `SOL_OFF_DRIVE);
	assign wr_odiv   = reg_wr & hit(reg_addr, `SOL_OFF_ODIV);
	assign wr_loopa  = reg_wr & hit(reg_addr, `SOL_OFF_LOOPA);
	assign wr_mode   = reg_wr & hit(reg_addr, `SOL_OFF_MODE);
	assign wr_stat   = reg_wr & hit(reg_addr, `SOL_OFF_STAT);
	assign wr_mask   = reg_wr & hit(reg_addr, `SOL_OFF_MASK);

	assign loop_mode  = mode_q[1:0];
	assign interp_sel = mode_q[3:2];
	assign new_int    = reg_wdata[`SOL_INT_HI:`SOL_INT_LO];
	assign new_low    = reg_wdata[`SOL_FRL_HI:`SOL_FRL_LO];

	// ==========================================================
	// Pin synchronisers
	sol_sync2 #(
		.W(2)
	) u_pin_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in ({loop_a_powerdown_pin, lock_detect_pin}),
		.sync_q   ({pd_sync, lock_sync})
	);

	// ==========================================================
	// Register writes
	always @(posedge clk) begin
		if (sys_rst) begin
			drive_q <= `SOL_RST_DRIVE;
			odiv_q  <= `SOL_RST_ODIV;
			loopa_q <= `SOL_RST_LOOPA;
			mode_q  <= `SOL_RST_MODE;
			mask_q  <= {`SOL_ST_W{1'b0}};
		end else begin
			if (wr_drive)
				drive_q <= reg_wdata[7:0];
			if (wr_odiv)
				odiv_q <= reg_wdata[31:0];
			if (wr_loopa)
				loopa_q <= reg_wdata;
			if (wr_mode)
				mode_q <= reg_wdata[3:0];
			if (wr_mask)
				mask_q <= reg_wdata[`SOL_ST_W-1:0];
		end
	end

	// ==========================================================
	// Events and sticky status
	always @* begin
		event_d = {`SOL_ST_W{1'b0}};
		// Lock lost while the loop is meant to run
		event_d[`SOL_ST_UNLOCK] = lock_prev_q & ~lock_sync & ~pd_sync;
		// Flag an integer part under the floor
		event_d[`SOL_ST_FBMIN] = wr_loopa & (new_int < `SOL_FB_MIN);
		// Flag zero low bits in integer mode
		event_d[`SOL_ST_LOWZ] = (wr_loopa & (loop_mode == `SOL_MODE_INT) & (new_low == 6'h00))
			| (wr_mode & (reg_wdata[1:0] == `SOL_MODE_INT)
			& (loopa_q[`SOL_FRL_HI:`SOL_FRL_LO] == 6'h00));
		status_d = status_q;
		if (wr_stat)
			status_d = status_d & ~reg_wdata[`SOL_ST_W-1:0];
		// Set beats a same-cycle clear
		status_d = status_d | event_d;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			status_q    <= {`SOL_ST_W{1'b0}};
			lock_prev_q <= 1'b0;
		end else begin
			status_q    <= status_d;
			lock_prev_q <= lock_sync;
		end
	end

	assign irq = |(status_q & mask_q);

	// ==========================================================
	// Read port
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= {`SOL_DW{1'b0}};
		end else if (reg_rd) begin
			case (reg_addr)
				`SOL_OFF_DRIVE: reg_rdata <= {32'h0000_0000, drive_q};
				`SOL_OFF_ODIV:  reg_rdata <= {8'h00, odiv_q};
				`SOL_OFF_LOOPA: reg_rdata <= loopa_q;
				`SOL_OFF_MODE:  reg_rdata <= {36'h0_0000_0000, mode_q};
				`SOL_OFF_STAT:  reg_rdata <= {37'h0_0000_0000, status_q};
				`SOL_OFF_MASK:  reg_rdata <= {37'h0_0000_0000, mask_q};
				default:        reg_rdata <= {`SOL_DW{1'b0}};
			endcase
		end else begin
			// Data stand only in the cycle after the strobe
			reg_rdata <= {`SOL_DW{1'b0}};
		end
	end

	// ==========================================================
	// First output drive standard
	assign first_out_drive_select = drive_q[1:0];

	always @(posedge clk) begin
		if (sys_rst) begin
			drive_cmos     <= 1'b1;
			drive_lvds     <= 1'b0;
			drive_pecl     <= 1'b0;
			drive_hcsl     <= 1'b0;
			first_out_n_oe <= 1'b0;
		end else begin
			drive_cmos     <= (drive_q[1:0] == `SOL_DRV_CMOS);
			drive_lvds     <= (drive_q[1:0] == `SOL_DRV_LVDS);
			drive_pecl     <= (drive_q[1:0] == `SOL_DRV_PECL);
			drive_hcsl     <= (drive_q[1:0] == `SOL_DRV_HCSL);
			first_out_n_oe <= (drive_q[1:0] != `SOL_DRV_CMOS);
		end
	end

	// ==========================================================
	// Output dividers
	// One divider per field
	sol_out_div u_div1 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.div_n   (odiv_field(odiv_q, 2'd0)),
		.out_q   (first_out_p),
		.out_n_q (first_out_n)
	);

	sol_out_div u_div2 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.div_n   (odiv_field(odiv_q, 2'd1)),
		.out_q   (second_out),
		.out_n_q ()
	);

	sol_out_div u_div3 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.div_n   (odiv_field(odiv_q, 2'd2)),
		.out_q   (third_out),
		.out_n_q ()
	);

	sol_out_div u_div4 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.div_n   (odiv_field(odiv_q, 2'd3)),
		.out_q   (fourth_out),
		.out_n_q ()
	);

	// ==========================================================
	// Loop A feedback word interpretation
	// Outputs are registered, so a mode change lands one cycle after the write
	always @(posedge clk) begin
		if (sys_rst) begin
			loop_a_fb_integer  <= 8'h00;
			loop_a_fb_fraction <= {`SOL_FRAC_W{1'b0}};
			loop_a_denominator <= 6'h00;
			interp_bits        <= 3'h0;
			sdm_bits           <= 3'h0;
		end else begin
			loop_a_fb_integer <= loopa_q[`SOL_INT_HI:`SOL_INT_LO];
			case (loop_mode)
				`SOL_MODE_FRAC: begin
					loop_a_fb_fraction <= {loopa_q[`SOL_FRH_HI:`SOL_FRH_LO],
						loopa_q[`SOL_FRL_HI:`SOL_FRL_LO]};
					loop_a_denominator <= 6'h00;
					interp_bits        <= 3'h0;
					sdm_bits           <= 3'h0;
				end
				`SOL_MODE_INT: begin
					loop_a_fb_fraction <= {loopa_q[`SOL_FRH_HI:`SOL_FRH_LO], 6'h00};
					loop_a_denominator <= 6'h00;
					// Top three bits routed by select
					if (interp_sel == `SOL_SEL_SDM) begin
						interp_bits <= 3'h0;
						sdm_bits    <= loopa_q[`SOL_FRH_HI:`SOL_FRH_HI-2];
					end else begin
						interp_bits <= loopa_q[`SOL_FRH_HI:`SOL_FRH_HI-2];
						sdm_bits    <= 3'h0;
					end
				end
				`SOL_MODE_RAT: begin
					loop_a_fb_fraction <= {loopa_q[`SOL_FRH_HI:`SOL_FRH_LO], 6'h00};
					loop_a_denominator <= loopa_q[`SOL_FRL_HI:`SOL_FRL_LO];
					interp_bits        <= 3'h0;
					sdm_bits           <= 3'h0;
				end
				default: begin
					loop_a_fb_fraction <= {`SOL_FRAC_W{1'b0}};
					loop_a_denominator <= 6'h00;
					interp_bits        <= 3'h0;
					sdm_bits           <= 3'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Subsystem power and shared pin
	always @(posedge clk) begin
		if (sys_rst) begin
			detector_pump_power_on <= 1'b0;
			oscillator_power_on    <= 1'b0;
			fb_div_power_on        <= 1'b0;
			readback_or_unlock_pin <= 1'b0;
		end else begin
			detector_pump_power_on <= loopa_q[`SOL_BIT_PFD] & ~pd_sync;
			oscillator_power_on    <= loopa_q[`SOL_BIT_VCO] & ~pd_sync;
			fb_div_power_on        <= loopa_q[`SOL_BIT_FBD] & ~pd_sync;
			if (loopa_q[`SOL_BIT_PINSEL])
				readback_or_unlock_pin <= irq;
			else
				readback_or_unlock_pin <= serial_read_data;
		end
	end

endmodule

// [verilog/sol_defines.vh]
// Constants for the synthesizer output and loop A configuration block.
// Assumes a single clock domain and a plain strobe-based register port.
// Functional notes
// - Drive select 00 gives single-ended CMOS with the complement pin floating, 01 LVDS, 10 LVPECL, 11 HCSL.
// - The output divider register holds four 8-bit fields: fourth 31:24, third 23:16, second 15:8, first 7:0.
// - A divider field n divides by n for n of 4 to 255 and by 256 plus n for n of 0 to 3.
// - In fractional mode the 28-bit fraction is bits 31:10 (upper 22) and bits 9:4 (lower 6).
// - In integer mode the top three fraction bits feed phase interpolation or sigma-delta, picked by a select field.
// - In rational mode bits 9:4 are the low six bits of the modulus instead of fraction bits.
// - Bit 3 powers the charge pump and detector, default 1.
// - Bit 2 powers the oscillator, default 1.
// - Bit 1 powers the feedback divider, default 1.
// - The loop power-down pin forces detector, oscillator and feedback divider off regardless of the bits.
// - Bit 0 at 0 puts serial read data on the shared pin, at 1 the interrupt, which is any masked status bit (unlock, integer floor or zero low bits).
`ifndef SOL_DEFINES_VH
`define SOL_DEFINES_VH

// ==========================================================
// Register port
`define SOL_AW          8
`define SOL_DW          40
`define SOL_OFF_DRIVE   8'h04
`define SOL_OFF_ODIV    8'h05
`define SOL_OFF_LOOPA   8'h06
`define SOL_OFF_MODE    8'h0f
`define SOL_OFF_STAT    8'h10
`define SOL_OFF_MASK    8'h11

// ==========================================================
// Reset values
`define SOL_RST_DRIVE   8'h00
`define SOL_RST_ODIV    32'h0000_0000
`define SOL_RST_LOOPA   40'h00_0000_000e
`define SOL_RST_MODE    4'h0

// ==========================================================
// Field layout
`define SOL_ODIV_W      8
`define SOL_INT_HI      39
`define SOL_INT_LO      32
`define SOL_FRH_HI      31
`define SOL_FRH_LO      10
`define SOL_FRL_HI      9
`define SOL_FRL_LO      4
`define SOL_BIT_PFD     3
`define SOL_BIT_VCO     2
`define SOL_BIT_FBD     1
`define SOL_BIT_PINSEL  0
`define SOL_FRAC_W      28
`define SOL_TOP3_HI     27
`define SOL_TOP3_LO     25

// ==========================================================
// Codes
`define SOL_DRV_CMOS    2'b00
`define SOL_DRV_LVDS    2'b01
`define SOL_DRV_PECL    2'b10
`define SOL_DRV_HCSL    2'b11
`define SOL_MODE_FRAC   2'b00
`define SOL_MODE_INT    2'b01
`define SOL_MODE_RAT    2'b10
`define SOL_SEL_SDM     2'b00
`define SOL_FB_MIN      8'h17
`define SOL_DIV_MIN     8'h04
`define SOL_DIV_WRAP    9'h100

// ==========================================================
// Interrupt status bits
`define SOL_ST_W        3
`define SOL_ST_UNLOCK   0
`define SOL_ST_FBMIN    1
`define SOL_ST_LOWZ     2

`endif

// [verilog/sol_out_div.v]
// One output divider: square wave at clk divided by the field value, or by 256 plus the field for fields below 4.
// Assumes clk stands in for the oscillator; field may change at any time.
`include "sol_defines.vh"
module sol_out_div #(
	parameter W = `SOL_ODIV_W
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire [W-1:0] div_n,
	output reg          out_q,
	output reg          out_n_q
);
	reg  [W:0] cnt_q;
	wire [W:0] ratio;
	wire [W:0] half;

	// ==========================================================
	// Ratio decode
	// Small fields wrap
	assign ratio = (div_n < `SOL_DIV_MIN) ? (`SOL_DIV_WRAP + {1'b0, div_n}) : {1'b0, div_n};
	assign half  = {1'b0, ratio[W:1]};

	// Wrap on shrink too, so a new field never stalls the count
	always @(posedge clk) begin
		if (sys_rst) begin
			cnt_q   <= {(W+1){1'b0}};
			out_q   <= 1'b0;
			out_n_q <= 1'b1;
		end else begin
			if (cnt_q >= ratio - 1'b1)
				cnt_q <= {(W+1){1'b0}};
			else
				cnt_q <= cnt_q + 1'b1;
			out_q   <= (cnt_q < half);
			out_n_q <= ~(cnt_q < half);
		end
	end
endmodule

// [verilog/sol_sync2.v]
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk.
module sol_sync2 #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_q
);
	reg [W-1:0] meta_q;

	// Only the second stage is visible to logic
	always @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule
